//--- src/tfr_register_bank.sv
// Temperature/fan register bank: readings, limits, passive threshold, duty loop timing.
// Assumes a byte-wide register port from a serial management bus slave on core_clk.
`timescale 1ns/10ps

module tfr_register_bank
	import tfr_pkg::*;
#(
	parameter longint BASE_TICK   = BASE_TICK_CYC,
	parameter longint SPEED_SLOW  = SPEED_SLOW_CYC,
	parameter longint SPEED_QUICK = SPEED_QUICK_CYC
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	// Converter results, one-cycle valid pulse
	input  wire logic        conv_valid,
	input  wire logic [10:0] local_temp_value,
	input  wire logic [10:0] remote_temp_value,
	// Fan control settings
	input  wire tfr_mode_t   mode,
	input  wire logic [2:0]  duty_update_rate_sel,
	input  wire logic [1:0]  adjust_hysteresis_sel,
	input  wire logic [1:0]  duty_step_sel,
	input  wire logic        quick_speed_sample,
	input  wire logic        use_remote_temp,
	input  wire logic [7:0]  duty_target,
	input  wire logic [7:0]  direct_duty,
	input  wire logic [15:0] fan_period_count,
	input  wire logic [15:0] fan_period_target,
	// Outputs
	output logic [7:0]       duty_cycle,
	output logic             readings_frozen
);
	// Readings and freeze
	logic [10:0] loc_q;
	logic [10:0] rem_q;
	logic        frz_q;
	// Limit registers
	logic [7:0]  loc_high_q;
	logic [7:0]  loc_low_q;
	logic [7:0]  loc_shut_q;
	logic [7:0]  rem_high_q;
	logic [7:0]  rem_low_q;
	logic [7:0]  rem_shut_q;
	logic [7:0]  loc_crit_q;
	logic [7:0]  rem_crit_q;
	logic [7:0]  passive_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	// Tick generation
	logic [31:0] tick_cnt_q;
	logic [31:0] tick_lim;
	logic        tick;
	logic [7:0]  duty_w;

	// Decode helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	wire rd_frac    = reg_rd && hit(reg_addr, ADDR_FRACTION);
	wire rd_rem_up  = reg_rd && hit(reg_addr, ADDR_REMOTE_UP);
	// Pad bits 4..3 are constant zero, so no stale bit can leak into them
	wire [7:0] frac_byte = {loc_q[2:0], 2'b00, rem_q[2:0]};

	// Readings refresh on every conversion unless frozen
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			loc_q <= {RST_TEMP_UP, RST_FRACTION[2:0]};
			rem_q <= {RST_TEMP_UP, RST_FRACTION[2:0]};
		end
		else if (conv_valid && !frz_q)
		begin
			loc_q <= local_temp_value;
			rem_q <= remote_temp_value;
		end
	end

	// Freeze from fraction read until remote upper read
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			frz_q <= 1'b0;
		else if (rd_frac)
			frz_q <= 1'b1;
		else if (rd_rem_up)
			frz_q <= 1'b0;
	end

	// Limit registers; reading registers have no write path
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			loc_high_q <= RST_LOC_HIGH;
			loc_low_q  <= RST_LOC_LOW;
			rem_high_q <= RST_REM_HIGH;
			rem_low_q  <= RST_REM_LOW;
			loc_shut_q <= RST_LOC_SHUT;
			rem_shut_q <= RST_REM_SHUT;
			loc_crit_q <= RST_LOC_CRIT;
			rem_crit_q <= RST_REM_CRIT;
			passive_q  <= RST_PASSIVE;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ADDR_LOC_HIGH: loc_high_q <= reg_wdata;
				ADDR_LOC_LOW:  loc_low_q  <= reg_wdata;
				ADDR_LOC_SHUT: loc_shut_q <= reg_wdata;
				ADDR_REM_HIGH: rem_high_q <= reg_wdata;
				ADDR_REM_LOW:  rem_low_q  <= reg_wdata;
				ADDR_REM_SHUT: rem_shut_q <= reg_wdata;
				ADDR_LOC_CRIT: loc_crit_q <= reg_wdata;
				ADDR_REM_CRIT: rem_crit_q <= reg_wdata;
				ADDR_PASSIVE:  passive_q  <= reg_wdata & PASSIVE_MASK;
				default:       passive_q  <= passive_q;
			endcase
		end
	end

	// Read multiplexer; high bytes are always live or frozen copies
	always_comb
	begin
		case (reg_addr)
			ADDR_FRACTION:  rdata_d = frac_byte;
			ADDR_LOCAL_UP:  rdata_d = loc_q[10:3];
			ADDR_REMOTE_UP: rdata_d = rem_q[10:3];
			ADDR_LOC_HIGH:  rdata_d = loc_high_q;
			ADDR_LOC_LOW:   rdata_d = loc_low_q;
			ADDR_LOC_SHUT:  rdata_d = loc_shut_q;
			ADDR_REM_HIGH:  rdata_d = rem_high_q;
			ADDR_REM_LOW:   rdata_d = rem_low_q;
			ADDR_REM_SHUT:  rdata_d = rem_shut_q;
			ADDR_LOC_CRIT:  rdata_d = loc_crit_q;
			ADDR_PASSIVE:   rdata_d = passive_q;
			ADDR_REM_CRIT:  rdata_d = rem_crit_q;
			default:        rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 8'h00;
		else if (reg_rd)
			rdata_q <= rdata_d;
	end

	// Update period: auto uses rate field, speed uses quick bit
	assign tick_lim = (mode == TFR_MODE_SPEED)
		? (quick_speed_sample ? 32'(SPEED_QUICK) : 32'(SPEED_SLOW))
		: 32'(32'(BASE_TICK) >> duty_update_rate_sel);
	assign tick = (tick_cnt_q >= 32'(tick_lim - 32'h1));

	// Free-running divider; converter timing never sees it
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tick_cnt_q <= 32'h0;
		else if (tick)
			tick_cnt_q <= 32'h0;
		else
			tick_cnt_q <= 32'(tick_cnt_q + 32'h1);
	end

	// Active temperature vs passive threshold, both 11-bit
	wire [10:0] act_temp = use_remote_temp ? rem_q : loc_q;
	wire        act_neg  = act_temp[10];
	wire        psv_stop = act_neg || (act_temp <= {passive_q, 3'b000});

	tfr_duty_loop u_loop (
		.core_clk              (core_clk),
		.nrst                  (nrst),
		.mode                  (mode),
		.update_tick           (tick),
		.duty_target           (duty_target),
		.direct_duty           (direct_duty),
		.duty_step_sel         (duty_step_sel),
		.adjust_hysteresis_sel (adjust_hysteresis_sel),
		.passive_stop          (psv_stop),
		.fan_period_count      (fan_period_count),
		.fan_period_target     (fan_period_target),
		.duty_cycle            (duty_w)
	);

	assign reg_rdata       = rdata_q;
	assign duty_cycle      = duty_w; // Flop output inside the loop
	assign readings_frozen = frz_q;
endmodule // tfr_register_bank

//--- common/tfr_pkg.sv
// Constants shared by the thermal/fan register bank.
// Assumes a single 250 MHz core clock domain.
package tfr_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_FRACTION   = 8'h06;
	localparam logic [7:0] ADDR_LOCAL_UP   = 8'h0A;
	localparam logic [7:0] ADDR_REMOTE_UP  = 8'h0B;
	localparam logic [7:0] ADDR_LOC_HIGH   = 8'h14;
	localparam logic [7:0] ADDR_LOC_LOW    = 8'h15;
	localparam logic [7:0] ADDR_LOC_SHUT   = 8'h16;
	localparam logic [7:0] ADDR_REM_HIGH   = 8'h18;
	localparam logic [7:0] ADDR_REM_LOW    = 8'h19;
	localparam logic [7:0] ADDR_REM_SHUT   = 8'h1A;
	localparam logic [7:0] ADDR_LOC_CRIT   = 8'h1B;
	localparam logic [7:0] ADDR_PASSIVE    = 8'h1C;
	localparam logic [7:0] ADDR_REM_CRIT   = 8'h1D;
	// Reset values
	localparam logic [7:0] RST_FRACTION    = 8'h00;
	localparam logic [7:0] RST_TEMP_UP     = 8'h80;
	localparam logic [7:0] RST_LOC_HIGH    = 8'h3C;
	localparam logic [7:0] RST_LOC_LOW     = 8'h00;
	localparam logic [7:0] RST_LOC_SHUT    = 8'h46;
	localparam logic [7:0] RST_REM_HIGH    = 8'h50;
	localparam logic [7:0] RST_REM_LOW     = 8'h00;
	localparam logic [7:0] RST_REM_SHUT    = 8'h64;
	localparam logic [7:0] RST_LOC_CRIT    = 8'h50;
	localparam logic [7:0] RST_PASSIVE     = 8'h00;
	localparam logic [7:0] RST_REM_CRIT    = 8'h69;
	localparam logic [7:0] RST_DUTY        = 8'h00;
	localparam logic [7:0] PASSIVE_MASK    = 8'h3F;
	// Speed loop dead band on period count
	localparam logic [15:0] PERIOD_DEADBAND = 16'h000A;
	// Update periods: 1/128 s at 250 MHz is the slowest rate tick
	localparam longint CLK_HZ              = 250000000;
	localparam longint BASE_TICK_NS        = 7812500;
	localparam longint BASE_TICK_CYC       = (BASE_TICK_NS * CLK_HZ) / 1000000000;
	// Speed loop ticks: slow 1 s, quick 0.25 s (plain defaults)
	localparam longint SPEED_SLOW_MS       = 1000;
	localparam longint SPEED_QUICK_MS      = 250;
	localparam longint SPEED_SLOW_CYC      = (SPEED_SLOW_MS * CLK_HZ) / 1000;
	localparam longint SPEED_QUICK_CYC     = (SPEED_QUICK_MS * CLK_HZ) / 1000;
	// Fan control modes
	typedef enum logic [1:0] {TFR_MODE_AUTO, TFR_MODE_SPEED, TFR_MODE_DIRECT} tfr_mode_t;
endpackage

//--- src/tfr_duty_loop.sv
// Duty-cycle update engine for the automatic and speed-regulating loops.
// Assumes update_tick is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
module tfr_duty_loop
	import tfr_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Control
	input  wire tfr_mode_t   mode,
	input  wire logic        update_tick,
	input  wire logic [7:0]  duty_target,
	input  wire logic [7:0]  direct_duty,
	input  wire logic [1:0]  duty_step_sel,
	input  wire logic [1:0]  adjust_hysteresis_sel,
	input  wire logic        passive_stop,
	input  wire logic [15:0] fan_period_count,
	input  wire logic [15:0] fan_period_target,
	// Result
	output logic [7:0]       duty_cycle
);
	logic [7:0] duty_q;
	logic [7:0] duty_d;
	logic [7:0] step;
	logic [7:0] hyst;
	logic [7:0] diff;
	logic       go_up;
	logic [7:0] move;
	logic [15:0] per_diff;
	logic        slow_fan;

	// Step 1..4 LSB and hysteresis 1..4 LSB
	assign step     = 8'({6'h00, duty_step_sel} + 8'h01);
	assign hyst     = 8'({6'h00, adjust_hysteresis_sel} + 8'h01);
	assign go_up    = duty_target > duty_q;
	assign diff     = go_up ? 8'(duty_target - duty_q) : 8'(duty_q - duty_target);
	assign move     = (diff < step) ? diff : step;
	assign slow_fan = fan_period_count > fan_period_target;
	assign per_diff = slow_fan ? 16'(fan_period_count - fan_period_target)
	                           : 16'(fan_period_target - fan_period_count);

	// Next duty value; 8-bit arithmetic limits precision
	always_comb
	begin
		duty_d = duty_q;
		case (mode)
			TFR_MODE_AUTO:
			begin
				if (passive_stop)
					duty_d = 8'h00;
				else if (update_tick && diff > hyst)
					duty_d = go_up ? 8'(duty_q + move) : 8'(duty_q - move);
			end
			TFR_MODE_SPEED:
			begin
				// Longer period means slow fan, so raise duty
				if (update_tick && per_diff > PERIOD_DEADBAND)
				begin
					if (slow_fan)
						duty_d = (8'hFF - duty_q < step) ? 8'hFF : 8'(duty_q + step);
					else
						duty_d = (duty_q < step) ? 8'h00 : 8'(duty_q - step);
				end
			end
			TFR_MODE_DIRECT: duty_d = direct_duty;
			default: duty_d = duty_q;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			duty_q <= RST_DUTY;
		else
			duty_q <= duty_d;
	end

	assign duty_cycle = duty_q;
endmodule // tfr_duty_loop

//--- testbench/tfr_register_bank_monitor.sv
// Port checker for the thermal/fan register bank.
// Bound into the bank; one clock domain, async active-low reset.
`timescale 1ns/10ps
module tfr_register_bank_monitor
	import tfr_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Fan side
	input wire tfr_mode_t   mode,
	input wire logic [1:0]  duty_step_sel,
	input wire logic [15:0] fan_period_count,
	input wire logic [15:0] fan_period_target,
	input wire logic [7:0]  duty_cycle,
	input wire logic        readings_frozen
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Period error, either sign
	wire logic [15:0] perr = (fan_period_count >= fan_period_target) ?
		fan_period_count - fan_period_target : fan_period_target - fan_period_count;
	// Steps of an 11-bit temperature fetch
	sequence frac_rd;
		reg_rd && reg_addr == ADDR_FRACTION;
	endsequence
	sequence rem_rd;
		reg_rd && reg_addr == ADDR_REMOTE_UP;
	endsequence
	// Speed loop never moves by more than one step per cycle
	property step_bound;
		logic [7:0] d;
		(mode == TFR_MODE_SPEED, d = duty_cycle) |=>
			((duty_cycle >= d) ? duty_cycle - d : d - duty_cycle) <= {6'h00, duty_step_sel} + 8'h01;
	endproperty
	frz_set_a: assert property (frac_rd |=> readings_frozen)
		else $error("freeze not set after fraction read");
	frz_clear_a: assert property (rem_rd |=> !readings_frozen)
		else $error("freeze not cleared after remote read");
	frz_hold_a: assert property (readings_frozen && !(reg_rd && reg_addr == ADDR_REMOTE_UP)
		|=> readings_frozen) else $error("freeze dropped early");
	frac_pad_a: assert property (frac_rd |=> reg_rdata[4:3] == 2'b00)
		else $error("fraction pad bits not zero");
	psv_pad_a: assert property (reg_rd && reg_addr == ADDR_PASSIVE |=> reg_rdata[7:6] == 2'b00)
		else $error("passive pad bits not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	band_stop_a: assert property (mode == TFR_MODE_SPEED && perr <= PERIOD_DEADBAND
		|=> $stable(duty_cycle)) else $error("duty moved inside dead band");
	step_max_a: assert property (step_bound)
		else $error("duty step too large");
endmodule // tfr_register_bank_monitor

bind tfr_register_bank tfr_register_bank_monitor u_mon (.core_clk, .nrst, .reg_addr, .reg_rd,
	.reg_rdata, .mode, .duty_step_sel, .fan_period_count, .fan_period_target, .duty_cycle,
	.readings_frozen);

//--- testbench/tfr_host_model.sv
// Management-bus host model: byte writes and reads on the register port.
// Assumes strobes are taken at the rising edge and data returns one cycle later.
`timescale 1ns/10ps
module tfr_host_model
(
	// Clock
	input  wire logic       core_clk,
	// Register port
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// Idle strobes low
	initial
	begin
		reg_addr = 8'hFF;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'hFF;
	end
	// Released lines show the inverse, so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// Data taken after the edge following the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
endmodule // tfr_host_model

//--- testbench/tfr_register_bank_tb_top.sv
// Self-checking bench for the thermal/fan register bank.
// Host model drives the register port; bench drives converter and fan inputs.
`timescale 1ns/10ps
module tfr_register_bank_tb_top;
	import tfr_pkg::*;
	logic        core_clk, nrst, conv_valid, quick_speed_sample, reg_wr, reg_rd;
	logic        readings_frozen;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, duty_target, duty_cycle, rv;
	logic [10:0] local_temp_value, remote_temp_value;
	logic [2:0]  duty_update_rate_sel;
	logic [1:0]  adjust_hysteresis_sel, duty_step_sel;
	logic [15:0] fan_period_count, fan_period_target;
	tfr_mode_t   mode;
	int          err_count, checks, cycles, n;
	// Addresses and power-on values in read order
	logic [7:0]  ra [12] = '{8'h06, 8'h0A, 8'h0B, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A,
		8'h1B, 8'h1C, 8'h1D};
	logic [7:0]  rr [12] = '{8'h00, 8'h80, 8'h80, 8'h3C, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64,
		8'h50, 8'h00, 8'h69};
	// Short tick counts keep loop tests brief
	tfr_register_bank #(.BASE_TICK(1024), .SPEED_SLOW(40), .SPEED_QUICK(10)) u_tfr_register_bank (
		.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .conv_valid,
		.local_temp_value, .remote_temp_value, .mode, .duty_update_rate_sel,
		.adjust_hysteresis_sel, .duty_step_sel, .quick_speed_sample, .use_remote_temp(1'b0),
		.duty_target, .direct_duty(8'h00), .fan_period_count, .fan_period_target, .duty_cycle,
		.readings_frozen);
	tfr_host_model u_tfr_host_model (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata);
	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			stop_test();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_tfr_host_model.rd(a, rv);
		chk(rv, exp);
	endtask
	task do_reset;
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
	endtask
	task conv(input logic [10:0] l, input logic [10:0] r);
		@(posedge core_clk);
		conv_valid <= 1'b1;
		local_temp_value <= l;
		remote_temp_value <= r;
		@(posedge core_clk);
		conv_valid <= 1'b0;
	endtask
	// Wait, bounded, while duty still shows v
	task hold_while(input logic [7:0] v, input int lim);
		n = 0;
		while (duty_cycle === v && n < lim)
		begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask
	// Power-on values, write-back, ignored writes, mid-run reset
	task t_regs;
		for (int i = 0; i < 12; i++) rd_chk(ra[i], rr[i]);
		for (int i = 3; i < 12; i++) u_tfr_host_model.wr(ra[i], 8'hFF);
		for (int i = 3; i < 12; i++) rd_chk(ra[i], (i == 10) ? 8'h3F : 8'hFF);
		u_tfr_host_model.wr(ADDR_LOCAL_UP, 8'h11);
		rd_chk(ADDR_LOCAL_UP, 8'h80);
		do_reset();
		for (int i = 3; i < 12; i++) rd_chk(ra[i], rr[i]);
		$display("t_regs done");
	endtask
	// Fraction read first freezes both upper bytes
	task t_freeze;
		conv(11'h0CD, 11'h2CB);
		rd_chk(ADDR_FRACTION, 8'hA3);
		conv(11'h0D0, 11'h1F3);
		rd_chk(ADDR_LOCAL_UP, 8'h19);
		rd_chk(ADDR_REMOTE_UP, 8'h59);
		conv(11'h0D0, 11'h1F3);
		rd_chk(ADDR_REMOTE_UP, 8'h3E);
		rd_chk(ADDR_LOCAL_UP, 8'h1A);
		$display("t_freeze done");
	endtask
	// Auto loop: hysteresis hold, remainder step, passive stop
	task t_auto;
		@(posedge core_clk);
		mode <= TFR_MODE_AUTO;
		duty_update_rate_sel <= 3'h7;
		duty_step_sel <= 2'h3;
		adjust_hysteresis_sel <= 2'h1;
		duty_target <= 8'h12;
		repeat (200) @(posedge core_clk);
		chk(duty_cycle, 8'h10);
		adjust_hysteresis_sel <= 2'h0;
		repeat (40) @(posedge core_clk);
		chk(duty_cycle, 8'h12);
		u_tfr_host_model.wr(ADDR_PASSIVE, 8'h3F);
		repeat (3) @(posedge core_clk);
		chk(duty_cycle, 8'h00);
		$display("t_auto done");
	endtask
	// Speed loop: dead band, fixed step, quick sample rate
	task t_speed;
		@(posedge core_clk);
		mode <= TFR_MODE_SPEED;
		quick_speed_sample <= 1'b1;
		duty_update_rate_sel <= 3'h0;
		fan_period_target <= 16'h0100;
		fan_period_count <= 16'h010A;
		repeat (40) @(posedge core_clk);
		chk(duty_cycle, 8'h00);
		fan_period_count <= 16'h0200;
		hold_while(8'h00, 30);
		chk(duty_cycle, 8'h04);
		hold_while(8'h04, 30);
		chk(8'(n), 8'h0A);
		@(posedge core_clk);
		quick_speed_sample <= 1'b0;
		hold_while(8'h08, 60);
		hold_while(8'h0C, 60);
		chk(8'(n), 8'h28);
		$display("t_speed done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		nrst = 1'b0;
		conv_valid = 1'b0;
		local_temp_value = 11'h000;
		remote_temp_value = 11'h000;
		mode = TFR_MODE_DIRECT;
		duty_update_rate_sel = 3'h4;
		adjust_hysteresis_sel = 2'h2;
		duty_step_sel = 2'h0;
		quick_speed_sample = 1'b0;
		duty_target = 8'h00;
		fan_period_count = 16'h0000;
		fan_period_target = 16'h0000;
		do_reset();
		t_regs();
		t_freeze();
		t_auto();
		t_speed();
		stop_test();
	end
endmodule // tfr_register_bank_tb_top
